// file: design/analog_frontend_params.svh
`ifndef ANALOG_FRONTEND_PARAMS_SVH
`define ANALOG_FRONTEND_PARAMS_SVH

// byte addresses of the registers
`define AFE_ADDR_AMP1      12'h000
`define AFE_ADDR_AMP2      12'h004
`define AFE_ADDR_FILT      12'h008
`define AFE_ADDR_FCLK      12'h00c
`define AFE_ADDR_FDIV      12'h010
`define AFE_ADDR_CREF      12'h014
`define AFE_ADDR_PUMP      12'h018
`define AFE_ADDR_CONV      12'h01c

// writable bit masks; unimplemented bits stay zero
`define AFE_MASK_FCLK      8'h3c
`define AFE_MASK_CREF      8'hcf
`define AFE_MASK_PUMP      8'h03
`define AFE_MASK_CONV      8'h01
`define AFE_RESET_BYTE     8'h00

// field positions
`define AFE_CHOP_BIT       7
`define AFE_MEASF_BIT      6
`define AFE_AUTO_BIT       5
`define AFE_PRE_LSB        2
`define AFE_PUMP_BIT       1
`define AFE_REG_BIT        0
`define AFE_BIAS_LSB       5
`define AFE_BIAS_W         2
`define AFE_S2GAIN_W       5
`define AFE_CUT_LSB        6
`define AFE_CUT_W          2
`define AFE_FGAIN_W        6
`define AFE_CUR_BIT        7
`define AFE_BAT_BIT        6
`define AFE_REF_W          4
`define AFE_PRE_W          3

// chopper clock and filter prescaler base
`define AFE_CLK_HZ         50000000
`define AFE_CHOP_HZ        12000
`define AFE_PRE_BASE_LOG2  3

`define AFE_RESP_OKAY      2'b00
`define AFE_RESP_SLVERR    2'b10

`endif

// file: design/analog_frontend_pkg.sv
package analog_frontend_pkg;

  typedef struct packed {
    logic [7:0] amp1;
    logic [7:0] amp2;
    logic [7:0] filt;
    logic [7:0] fclk;
    logic [7:0] fdiv;
    logic [7:0] cref;
    logic [7:0] pump;
    logic [7:0] conv;
  } regs_t;

  typedef struct packed {
    logic       chopper_on;
    logic       chopClk;
    logic [1:0] lownoiseBias;
    logic [4:0] stage2GainCode;
    logic [7:0] amp2OffsetCode;
    logic [1:0] filterCutoffSel;
    logic [5:0] filterGainCode;
    logic       filterClkEn;
    logic       sensorCurrentOn;
    logic       batterySenseOn;
    logic [3:0] currentRefCode;
    logic       regulatorPowered;
    logic       pumpPowered;
  } analog_ctrl_t;

  typedef struct packed {
    logic       convStart;
    logic       convFromFilter;
    logic       convSelFilter;
  } conv_ctrl_t;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRESP = 2'b01,
    BUS_RDATA = 2'b10
  } bus_state_t;

endpackage

// file: design/analog_frontend_control.sv
// Summary of operation
// - chopper bit supplies 12kHz chopping clock
// - stage2 gain code, gain 1+code/32
// - bits 6..5 drive low-noise bias
// - 8-bit offset code for second amplifier
// - cutoff code selects 9 to 12Hz
// - filter gain code, gain 56+4*code
// - filter-measure status bit is read-only
// - auto-measure starts filter conversions
// - prescaler divides by 8 up to 1024
// - divider divides by value plus one
// - bit 7 enables constant current circuit
// - bit 6 enables battery sense circuit
// - 4-bit code selects reference voltage
// - unimplemented bits read zero, ignore writes
// - regulator off powers down pump too
// - pump doubles supply only when enabled
// - halt forces charge pump off
// - auto-measure forces filter input channel
// - newest conversion request takes priority
// - pump bit 1, regulator bit 0
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`include "analog_frontend_params.svh"

module analog_frontend_control #(
  parameter int CLK_HZ  = `AFE_CLK_HZ,
  parameter int CHOP_HZ = `AFE_CHOP_HZ
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  // axi4-lite slave
  input  wire logic [11:0]                       s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [11:0]                       s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  // system side
  input  wire logic                              haltMode,
  input  wire logic                              filterSampleTick,
  input  wire logic                              convRunning,
  output analog_frontend_pkg::analog_ctrl_t      analogCtrl,
  output analog_frontend_pkg::conv_ctrl_t        convCtrl
);
  import analog_frontend_pkg::*;

  // half period of the chopping clock, rounded down but at least 1, so it runs slow only when CLK_HZ < 2*CHOP_HZ
  localparam int CHOP_HALF = (CLK_HZ / (2 * CHOP_HZ)) < 1 ? 1 : CLK_HZ / (2 * CHOP_HZ);
  localparam int CHOP_W    = $clog2(CHOP_HALF + 1);
  localparam int PRE_W     = 10;

  typedef struct packed {
    regs_t               regs;
    bus_state_t          bus;
    logic                awTaken;
    logic                wTaken;
    logic [11:0]         awAddr;
    logic [31:0]         wData;
    logic [3:0]          wStrb;
    logic                bValid;
    logic [1:0]          bResp;
    logic                rValid;
    logic [31:0]         rData;
    logic [1:0]          rResp;
    logic                awReady;
    logic                wReady;
    logic                arReady;
    logic [CHOP_W-1:0]   chopCnt;
    logic                chopClk;
    logic [PRE_W-1:0]    preCnt;
    logic [7:0]          divCnt;
    logic                fclkEn;
    logic                convStart;
    logic                convFromFilter;
    analog_ctrl_t        out;
  } state_t;

  state_t state_reg;
  state_t state_next;

  function automatic logic [7:0] read_reg(input regs_t r, input logic [11:0] a,
                                          output logic hit);
    logic [7:0] v;
    v   = 8'h00;
    hit = 1'b1;
    case (a)
      `AFE_ADDR_AMP1: v = r.amp1;
      `AFE_ADDR_AMP2: v = r.amp2;
      `AFE_ADDR_FILT: v = r.filt;
      `AFE_ADDR_FCLK: v = r.fclk;
      `AFE_ADDR_FDIV: v = r.fdiv;
      `AFE_ADDR_CREF: v = r.cref;
      `AFE_ADDR_PUMP: v = r.pump;
      `AFE_ADDR_CONV: v = r.conv;
      default:        hit = 1'b0;
    endcase
    return v;
  endfunction

  logic [7:0]       wByte;
  logic [7:0]       rByte;
  logic             rHit;
  logic             wHit;
  logic             settingChanged;
  logic [PRE_W-1:0] preLimit;
  logic             preTick;
  logic             autoOn;

  always_comb begin
    state_next     = state_reg;
    wByte          = state_reg.wData[7:0];
    rByte          = 8'h00;
    rHit           = 1'b0;
    wHit           = 1'b1;
    settingChanged = 1'b0;
    preLimit       = '0;
    preTick        = 1'b0;
    autoOn         = state_reg.regs.fclk[`AFE_AUTO_BIT];

    // ************************************************************
    // register bus
    // ************************************************************
    state_next.convStart = 1'b0;
    case (state_reg.bus)
      BUS_IDLE: begin
        if (s_axi_awvalid && state_reg.awReady) begin
          state_next.awTaken = 1'b1;
          state_next.awAddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_reg.wReady) begin
          state_next.wTaken = 1'b1;
          state_next.wData  = s_axi_wdata;
          state_next.wStrb  = s_axi_wstrb;
        end
        if (state_reg.awTaken && state_reg.wTaken) begin
          state_next.awTaken = 1'b0;
          state_next.wTaken  = 1'b0;
          state_next.bValid  = 1'b1;
          state_next.bResp   = `AFE_RESP_OKAY;
          state_next.bus     = BUS_WRESP;
          if (state_reg.wStrb[0]) begin
            case (state_reg.awAddr)
              `AFE_ADDR_AMP1: state_next.regs.amp1 = wByte;
              `AFE_ADDR_AMP2: state_next.regs.amp2 = wByte;
              `AFE_ADDR_FILT: state_next.regs.filt = wByte;
              `AFE_ADDR_FCLK: begin
                // status bit kept, other unimplemented bits dropped
                state_next.regs.fclk = (wByte & `AFE_MASK_FCLK)
                                     | (state_reg.regs.fclk & ~`AFE_MASK_FCLK);
                settingChanged = 1'b1;
              end
              `AFE_ADDR_FDIV: begin
                state_next.regs.fdiv = wByte;
                settingChanged = 1'b1;
              end
              `AFE_ADDR_CREF: state_next.regs.cref = wByte & `AFE_MASK_CREF;
              `AFE_ADDR_PUMP: state_next.regs.pump = wByte & `AFE_MASK_PUMP;
              `AFE_ADDR_CONV: begin
                // software start strobe, self-clearing
                state_next.convStart      = wByte[0];
                state_next.convFromFilter = 1'b0;
              end
              default: wHit = 1'b0;
            endcase
          end else begin
            rByte = read_reg(state_reg.regs, state_reg.awAddr, wHit);
          end
          if (!wHit) begin
            state_next.bResp = `AFE_RESP_SLVERR;
          end
        end else if (s_axi_arvalid && state_reg.arReady) begin
          rByte = read_reg(state_reg.regs, s_axi_araddr, rHit);
          state_next.rData  = {24'h000000, rByte};
          state_next.rResp  = rHit ? `AFE_RESP_OKAY : `AFE_RESP_SLVERR;
          state_next.rValid = 1'b1;
          state_next.bus    = BUS_RDATA;
        end
      end
      BUS_WRESP: begin
        if (s_axi_bready) begin
          state_next.bValid = 1'b0;
          state_next.bus    = BUS_IDLE;
        end
      end
      BUS_RDATA: begin
        if (s_axi_rready) begin
          state_next.rValid = 1'b0;
          state_next.bus    = BUS_IDLE;
        end
      end
      default: state_next.bus = BUS_IDLE;
    endcase
    // ready flags come from flops; low for one cycle after reset
    state_next.awReady = (state_next.bus == BUS_IDLE) && !state_next.awTaken;
    state_next.wReady  = (state_next.bus == BUS_IDLE) && !state_next.wTaken;
    state_next.arReady = (state_next.bus == BUS_IDLE)
                       && !(state_next.awTaken && state_next.wTaken);

    // ************************************************************
    // filter clock generator
    // ************************************************************
    preLimit = PRE_W'((1 << (`AFE_PRE_BASE_LOG2
             + state_reg.regs.fclk[`AFE_PRE_LSB +: `AFE_PRE_W])) - 1);
    state_next.fclkEn = 1'b0;
    if (settingChanged) begin
      state_next.preCnt = '0;
      state_next.divCnt = 8'h00;
    end else if (state_reg.preCnt >= preLimit) begin
      state_next.preCnt = '0;
      preTick           = 1'b1;
    end else begin
      state_next.preCnt = state_reg.preCnt + 1'b1;
    end
    if (preTick) begin
      if (state_reg.divCnt >= state_reg.regs.fdiv) begin
        state_next.divCnt = 8'h00;
        state_next.fclkEn = 1'b1;
      end else begin
        state_next.divCnt = state_reg.divCnt + 8'h01;
      end
    end

    // ************************************************************
    // chopping clock
    // ************************************************************
    if (!state_reg.regs.amp1[`AFE_CHOP_BIT]) begin
      state_next.chopCnt = '0;
      state_next.chopClk = 1'b0;
    end else if (state_reg.chopCnt >= CHOP_W'(CHOP_HALF - 1)) begin
      state_next.chopCnt = '0;
      state_next.chopClk = ~state_reg.chopClk;
    end else begin
      state_next.chopCnt = state_reg.chopCnt + 1'b1;
    end

    // ************************************************************
    // automatic conversion
    // ************************************************************
    // filter-side status tracks auto-measure; hardware owned
    state_next.regs.fclk[`AFE_MEASF_BIT] = autoOn;
    if (autoOn && filterSampleTick) begin
      // a fresh start overrides one still running
      state_next.convStart      = 1'b1;
      state_next.convFromFilter = 1'b1;
    end
    state_next.regs.conv = {7'h00, convRunning};

    // ************************************************************
    // amplifier outputs
    // ************************************************************
    state_next.out.chopper_on      = state_reg.regs.amp1[`AFE_CHOP_BIT];
    state_next.out.chopClk         = state_reg.chopClk;
    state_next.out.lownoiseBias    = state_reg.regs.amp1[`AFE_BIAS_LSB +: `AFE_BIAS_W];
    state_next.out.stage2GainCode  = state_reg.regs.amp1[`AFE_S2GAIN_W-1:0];
    state_next.out.amp2OffsetCode  = state_reg.regs.amp2;

    // ************************************************************
    // filter outputs
    // ************************************************************
    state_next.out.filterCutoffSel = state_reg.regs.filt[`AFE_CUT_LSB +: `AFE_CUT_W];
    state_next.out.filterGainCode  = state_reg.regs.filt[`AFE_FGAIN_W-1:0];
    state_next.out.filterClkEn     = state_reg.fclkEn;

    // ************************************************************
    // sensor current outputs
    // ************************************************************
    state_next.out.sensorCurrentOn = state_reg.regs.cref[`AFE_CUR_BIT];
    state_next.out.batterySenseOn  = state_reg.regs.cref[`AFE_BAT_BIT];
    state_next.out.currentRefCode  = state_reg.regs.cref[`AFE_REF_W-1:0];

    // ************************************************************
    // power outputs
    // ************************************************************
    state_next.out.regulatorPowered = state_reg.regs.pump[`AFE_REG_BIT];
    // halt shuts the pump off without touching the stored enable
    state_next.out.pumpPowered = state_reg.regs.pump[`AFE_REG_BIT]
                               & state_reg.regs.pump[`AFE_PUMP_BIT]
                               & ~haltMode;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready = state_reg.awReady;
  assign s_axi_wready  = state_reg.wReady;
  assign s_axi_bvalid  = state_reg.bValid;
  assign s_axi_bresp   = state_reg.bResp;
  assign s_axi_arready = state_reg.arReady;
  assign s_axi_rvalid  = state_reg.rValid;
  assign s_axi_rdata   = state_reg.rData;
  assign s_axi_rresp   = state_reg.rResp;
  assign analogCtrl    = state_reg.out;
  assign convCtrl      = {state_reg.convStart, state_reg.convFromFilter,
                          state_reg.regs.fclk[`AFE_AUTO_BIT]};

endmodule

// file: tb/analog_frontend_control_checker.sv
`include "analog_frontend_params.svh"

module analog_frontend_control_checker (
  input wire logic                              clk,
  input wire logic                              rst,
  input wire logic [11:0]                       s_axi_araddr,
  input wire logic                              s_axi_arvalid,
  input wire logic                              s_axi_arready,
  input wire logic [31:0]                       s_axi_rdata,
  input wire logic                              s_axi_rvalid,
  input wire logic                              s_axi_rready,
  input wire logic [1:0]                        s_axi_bresp,
  input wire logic                              s_axi_bvalid,
  input wire logic                              s_axi_bready,
  input wire logic                              haltMode,
  input wire logic                              filterSampleTick,
  input wire analog_frontend_pkg::analog_ctrl_t analogCtrl,
  input wire analog_frontend_pkg::conv_ctrl_t   convCtrl
);
  timeunit 1ns;
  timeprecision 1ps;
  import analog_frontend_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // address of the read in flight, so read data can be judged per register
  logic [11:0] rdAddr_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdAddr_reg <= 12'h000;
    else if (s_axi_arvalid && s_axi_arready) rdAddr_reg <= s_axi_araddr;
  end
  pump_gate_a: assert property (!analogCtrl.regulatorPowered |-> !analogCtrl.pumpPowered)
    else $error("pump powered while regulator off");
  halt_pump_a: assert property (haltMode ##1 haltMode |-> !analogCtrl.pumpPowered)
    else $error("pump powered during halt");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  fclk_bits_a: assert property (s_axi_rvalid && rdAddr_reg == `AFE_ADDR_FCLK |->
    s_axi_rdata[7] == 1'b0 && s_axi_rdata[1:0] == 2'b00 && s_axi_rdata[6] == s_axi_rdata[5])
    else $error("filter clock control read wrong");
  cref_hole_a: assert property (s_axi_rvalid && rdAddr_reg == `AFE_ADDR_CREF |->
    s_axi_rdata[5:4] == 2'b00) else $error("current ref hole bits set");
  pump_hole_a: assert property (s_axi_rvalid && rdAddr_reg == `AFE_ADDR_PUMP |->
    s_axi_rdata[7:2] == 6'h00) else $error("pump ctrl hole bits set");
  clk_pulse_a: assert property (analogCtrl.filterClkEn |=> !analogCtrl.filterClkEn)
    else $error("filter clock enable longer than one cycle");
  auto_start_a: assert property (filterSampleTick && convCtrl.convSelFilter |-> ##[1:2] convCtrl.convStart)
    else $error("no automatic conversion start");
  chop_off_a: assert property (!analogCtrl.chopper_on [*3] |-> !analogCtrl.chopClk)
    else $error("chopping clock while chopper off");
  cover property (analogCtrl.filterClkEn);
  cover property (convCtrl.convStart && convCtrl.convFromFilter);
  cover property (s_axi_bvalid && s_axi_bresp == `AFE_RESP_SLVERR);
endmodule

bind analog_frontend_control analog_frontend_control_checker analog_frontend_control_checker_i (
  .clk(clk), .rst(rst), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .haltMode(haltMode), .filterSampleTick(filterSampleTick),
  .analogCtrl(analogCtrl), .convCtrl(convCtrl));

// file: tb/test_analog_frontend_control.sv
`include "analog_frontend_params.svh"

module test_analog_frontend_control;
  timeunit 1ns;
  timeprecision 1ps;
  import analog_frontend_pkg::*;
  // small clock so one chopper half period is 10 cycles
  localparam int CLK_HZ  = 240000;
  localparam int CHOP_HZ = 12000;
  logic         clk, rst, haltMode, filterSampleTick, convRunning;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  analog_ctrl_t analogCtrl;
  conv_ctrl_t   convCtrl;
  int           err_count, compares;

  analog_frontend_control #(.CLK_HZ(CLK_HZ), .CHOP_HZ(CHOP_HZ)) analog_frontend_control_i (
    .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .haltMode(haltMode), .filterSampleTick(filterSampleTick), .convRunning(convRunning),
    .analogCtrl(analogCtrl), .convCtrl(convCtrl));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ************************
  // bus and compare tasks
  // ************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ready is sampled at the edge, before the slave's own updates land
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask

  task automatic wrrd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
    wr(a, d, 4'h1, `AFE_RESP_OKAY);
    rd(a, {24'h000000, e}, `AFE_RESP_OKAY);
  endtask

  // cycles between two filter clock pulses
  task automatic fcase(input logic [2:0] pre, input logic [7:0] dv, input int n);
    int c;
    c = 0;
    wr(`AFE_ADDR_FDIV, dv, 4'h1, `AFE_RESP_OKAY);
    wr(`AFE_ADDR_FCLK, {3'b000, pre, 2'b00}, 4'h1, `AFE_RESP_OKAY);
    do @(posedge clk); while (analogCtrl.filterClkEn !== 1'b1);
    do begin
      @(posedge clk);
      c++;
    end while (analogCtrl.filterClkEn !== 1'b1);
    chk(c, n);
  endtask

  task automatic final_report();
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************************
  // tests
  // ************************
  initial begin
    int i;
    err_count = 0;
    compares = 0;
    rst = 1'b1;
    {haltMode, filterSampleTick, convRunning} = 3'b000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 8; i++) rd(12'(4 * i), 32'h0, `AFE_RESP_OKAY);
    wrrd(`AFE_ADDR_AMP1, 8'hb4, 8'hb4);
    wrrd(`AFE_ADDR_AMP2, 8'ha5, 8'ha5);
    wrrd(`AFE_ADDR_FILT, 8'h81, 8'h81);
    wrrd(`AFE_ADDR_FCLK, 8'hff, 8'h7c);
    wrrd(`AFE_ADDR_FDIV, 8'h5a, 8'h5a);
    wrrd(`AFE_ADDR_CREF, 8'hb9, 8'h89);
    wrrd(`AFE_ADDR_PUMP, 8'hfe, 8'h02);
    chk({analogCtrl.chopper_on, analogCtrl.lownoiseBias, analogCtrl.stage2GainCode,
         analogCtrl.amp2OffsetCode, analogCtrl.filterCutoffSel,
         analogCtrl.filterGainCode}, 32'h00b4a581);
    chk({analogCtrl.sensorCurrentOn, analogCtrl.batterySenseOn, analogCtrl.currentRefCode,
         analogCtrl.regulatorPowered, analogCtrl.pumpPowered,
         convCtrl.convSelFilter}, 32'h149);
    wr(`AFE_ADDR_AMP2, 8'h3c, 4'he, `AFE_RESP_OKAY);
    rd(`AFE_ADDR_AMP2, 32'ha5, `AFE_RESP_OKAY);
    wr(12'h020, 8'hff, 4'h1, `AFE_RESP_SLVERR);
    rd(12'h020, 32'h0, `AFE_RESP_SLVERR);
    for (i = 0; i < 4; i++) begin
      // supply taken as below 3.6V, so the pump goes on only when both the pump and regulator bits are set
      wr(`AFE_ADDR_PUMP, 8'(i), 4'h1, `AFE_RESP_OKAY);
      // outputs follow the register one edge later
      @(posedge clk);
      chk({analogCtrl.regulatorPowered, analogCtrl.pumpPowered}, {i[0], i == 3});
    end
    haltMode <= 1'b1;
    repeat (3) @(posedge clk);
    chk({analogCtrl.regulatorPowered, analogCtrl.pumpPowered}, 2'b10);
    haltMode <= 1'b0;
    repeat (3) @(posedge clk);
    chk({analogCtrl.regulatorPowered, analogCtrl.pumpPowered}, 2'b11);
    fcase(3'd0, 8'd2, 24);
    fcase(3'd2, 8'd0, 32);
    fcase(3'd7, 8'd1, 2048);
    wrrd(`AFE_ADDR_FCLK, 8'h40, 8'h00);
    wrrd(`AFE_ADDR_FCLK, 8'h20, 8'h60);
    filterSampleTick <= 1'b1;
    @(posedge clk);
    filterSampleTick <= 1'b0;
    for (i = 0; i < 4 && convCtrl.convStart !== 1'b1; i++) @(posedge clk);
    chk({convCtrl.convStart, convCtrl.convFromFilter, convCtrl.convSelFilter}, 3'b111);
    convRunning <= 1'b1;
    wr(`AFE_ADDR_CONV, 8'h01, 4'h1, `AFE_RESP_OKAY);
    chk(convCtrl.convFromFilter, 1'b0);
    rd(`AFE_ADDR_CONV, 32'h1, `AFE_RESP_OKAY);
    wr(`AFE_ADDR_FCLK, 8'h00, 4'h1, `AFE_RESP_OKAY);
    chk(convCtrl.convSelFilter, 1'b0);
    // start at a rising phase, never in the middle of a high one
    do @(posedge clk); while (analogCtrl.chopClk !== 1'b0);
    do @(posedge clk); while (analogCtrl.chopClk !== 1'b1);
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (analogCtrl.chopClk === 1'b1);
    chk(i, CLK_HZ / (2 * CHOP_HZ));
    wr(`AFE_ADDR_AMP1, 8'h00, 4'h1, `AFE_RESP_OKAY);
    repeat (12) @(posedge clk);
    chk(analogCtrl.chopClk, 1'b0);
    final_report();
  end

  // whole run is a few thousand cycles
  initial begin
    #400000;
    err_count++;
    final_report();
  end
endmodule
